// file: src/cbm_pkg.sv
// constants for the clock, boot and supply fault monitor
package cbm_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] A_MCLK_CFG = 8'h00; // main_clock_config_reg
    localparam logic [7:0] A_CLK_CFG  = 8'h04; // clock source control
    localparam logic [7:0] A_CLK_STAT = 8'h08; // clock_status_reg
    localparam logic [7:0] A_FCC_CTL  = 8'h0c; // frequency_counter control
    localparam logic [7:0] A_FCC_CNT  = 8'h10; // frequency_counter result
    localparam logic [7:0] A_INT_ST   = 8'h14; // sticky events, w1c
    localparam logic [7:0] A_INT_MSK  = 8'h18; // event mask
    localparam logic [7:0] A_BOR_CFG  = 8'h1c; // brownout warning stage
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         F_MWIN_LO = 1;     // window field [4:1]
    localparam logic [3:0] MWIN_RST  = 4'hc;  // 12 low_freq_clock cycles
    localparam logic [3:0] MWIN_MAX  = 4'hc;
    localparam int         F_HF_START = 0;    // write 1: start crystal
    localparam int         F_HF_EXT   = 1;    // external fast input select
    localparam int         F_LF_LO    = 2;    // slow source [3:2]
    localparam logic [1:0] LF_INT  = 2'h0;    // internal_slow_oscillator
    localparam logic [1:0] LF_XTAL = 2'h1;    // low_freq_crystal
    localparam logic [1:0] LF_EXT  = 2'h2;    // external_slow_clock_input
    localparam logic [1:0] MODE_DEEP_STBY = 2'h2;
    localparam logic [1:0] MODE_SHUTDOWN  = 2'h3;
    localparam logic [7:0] FCC_REFS_RST   = 8'h01;
    // status bits
    localparam int ST_GOOD = 0, ST_OFF = 1, ST_LFDEAD = 2, ST_MFAULT = 3;
    localparam int ST_VDD = 4, ST_VBAT = 5, ST_WARN = 6, ST_BOOT = 7;
    // event bits
    localparam int INT_W = 8;
    localparam int I_MCLK = 0, I_GOOD = 1, I_OFF = 2, I_LF = 3;
    localparam int I_VDD = 4, I_VBAT = 5, I_FCC = 6, I_BOOT = 7;
    // pin positions in the synchroniser vector
    localparam int PIN_W = 13;
    localparam int P_MCLK = 0, P_LF = 1, P_HF = 2, P_SRC = 3, P_REF = 4;
    localparam int P_VDD = 5, P_VBAT = 6, P_WARN = 7, P_CFGE = 8;
    localparam int P_TRIME = 9, P_BDONE = 10, P_MODE = 11;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 10;
    localparam int HF_STUCK_NS  = 2000;  // no fast edge for this long
    localparam int HF_STUCK_CYC = (HF_STUCK_NS * CLK_MHZ + 999) / 1000;
    localparam int LF_STUCK_US  = 200;   // no slow edge for this long
    localparam int LF_STUCK_CYC = LF_STUCK_US * CLK_MHZ;
    localparam int BOOT_TO_US   = 2000;  // boot routine time limit
    localparam int BOOT_TO_CYC  = BOOT_TO_US * CLK_MHZ;
    localparam int HF_GOOD_EDGES = 1024; // edges before fast clock is good
    // frequency counter states, gray order
    typedef enum logic [1:0] {
        FCC_IDLE = 2'b00, FCC_ARM = 2'b01, FCC_RUN = 2'b11, FCC_DONE = 2'b10
    } cbm_fcc_t;
endpackage : cbm_pkg

// file: src/cbm_monitor.sv
// clock, boot and supply fault monitor with apb registers
`timescale 1ns/1ps
// Operation
// - main clock idle 1-12 slow cycles: fault
// - main clock fault issues boot reset
// - enable bit starts main clock monitor
// - monitor idle in deep standby, shutdown
// - report fast crystal started successfully
// - detect stuck external fast clock input
// - crystal start or ext select clears flags
// - slow clock checked only when crystal or externally sourced
// - slow monitor checks stuck only, no frequency
// - main supply violation follows supply state
// - battery supply violation follows battery state
// - count source periods over reference window
// - failed boot routine issues boot reset
// - integrity errors or timeout mean boot failure
// - warning trip: nmi, rearm as reset supervisor
module cbm_monitor import cbm_pkg::*; #(
    parameter int BOOT_TO = BOOT_TO_CYC  // boot timeout in cycles
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // monitored clocks and supplies, asynchronous
    input  wire logic        MCLK_ACT,
    input  wire logic        LF_CLK,
    input  wire logic        HF_CLK,
    input  wire logic        FCC_SRC,
    input  wire logic        FCC_REF,
    input  wire logic        VDD_LOW,
    input  wire logic        VBAT_LOW,
    input  wire logic        VDD_WARN,
    // boot routine status and operating mode, asynchronous
    input  wire logic        BCFG_ERR,
    input  wire logic        TRIM_ERR,
    input  wire logic        BOOT_DONE,
    input  wire logic [1:0]  MODE,
    // fault outputs
    output logic             BOOT_RST,
    output logic             VDD_VIOL,
    output logic             VBAT_VIOL,
    output logic             BOR_RST,
    output logic             NMI,
    output logic             IRQ
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction : rise
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_W-1:0] s1_reg;   // first stage, read by s2 only
    logic [PIN_W-1:0] s2_reg;   // safe level
    logic [PIN_W-1:0] pv_reg;   // previous safe level
    wire  [PIN_W-1:0] pins = {MODE, BOOT_DONE, TRIM_ERR, BCFG_ERR, VDD_WARN,
                              VBAT_LOW, VDD_LOW, FCC_REF, FCC_SRC, HF_CLK, LF_CLK, MCLK_ACT};
    // two flops per pin, a third for edges
    always_ff @(posedge CLK) begin
        if (RST) begin
            s1_reg <= '0;
            s2_reg <= '0;
            pv_reg <= '0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            pv_reg <= s2_reg;
        end
    end
    // edges seen at 10 MHz; inputs must toggle below half that
    wire       m_edge  = s2_reg[P_MCLK] ^ pv_reg[P_MCLK];  // any toggle is activity
    wire       lf_edge = rise(s2_reg[P_LF], pv_reg[P_LF]);
    wire       hf_edge = rise(s2_reg[P_HF], pv_reg[P_HF]);
    wire       src_edge = rise(s2_reg[P_SRC], pv_reg[P_SRC]);
    wire       ref_edge = rise(s2_reg[P_REF], pv_reg[P_REF]);
    wire [1:0] mode    = s2_reg[P_MODE+1:P_MODE];
    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic             men_reg;     // main_clock_dead_check_enable
    logic [3:0]       mwin_reg;    // window in slow cycles
    logic             hf_ext_reg;  // external fast input in use
    logic [1:0]       lf_src_reg;  // slow clock source
    logic [7:0]       refs_reg;    // reference periods per count
    logic [INT_W-1:0] msk_reg;     // interrupt mask
    logic             arm_reg;     // warning stage armed
    logic             pready_reg;
    logic             pslverr_reg;
    logic [31:0]      prdata_reg;
    wire acc    = PSEL & PENABLE;
    wire wr_en  = acc & PWRITE & pready_reg;   // write lands at pready edge
    wire hf_start = wr_en & (PADDR == A_CLK_CFG) & PWDATA[F_HF_START];
    wire ext_sel  = wr_en & (PADDR == A_CLK_CFG) & PWDATA[F_HF_EXT] & ~hf_ext_reg;
    wire fcc_go   = wr_en & (PADDR == A_FCC_CTL) & PWDATA[0];
    wire [INT_W-1:0] w1c = (wr_en & (PADDR == A_INT_ST)) ? PWDATA[INT_W-1:0] : '0;
    // clamp the window into 1..12
    wire [3:0] mwin = (mwin_reg == 4'h0) ? 4'h1 :
                      (mwin_reg > MWIN_MAX) ? MWIN_MAX : mwin_reg;
    // configuration writes
    always_ff @(posedge CLK) begin
        if (RST) begin
            men_reg    <= 1'b0;
            mwin_reg   <= MWIN_RST;
            hf_ext_reg <= 1'b0;
            lf_src_reg <= LF_INT;
            refs_reg   <= FCC_REFS_RST;
            msk_reg    <= '0;
        end else if (wr_en) begin
            case (PADDR)
                A_MCLK_CFG: begin
                    men_reg  <= PWDATA[0];
                    mwin_reg <= PWDATA[F_MWIN_LO+3:F_MWIN_LO];
                end
                A_CLK_CFG: begin
                    hf_ext_reg <= PWDATA[F_HF_EXT];
                    lf_src_reg <= PWDATA[F_LF_LO+1:F_LF_LO];
                end
                A_FCC_CTL: refs_reg <= PWDATA[15:8];
                A_INT_MSK: msk_reg  <= PWDATA[INT_W-1:0];
                default: ;  // other offsets store nothing in this block
            endcase
        end
    end
    // ------------------------------------------------------------
    // main clock monitor
    // ------------------------------------------------------------
    logic [3:0] mcnt_reg;    // slow edges since last activity
    logic       mfault_reg;  // sticky until reset
    // off in deep standby and shutdown to save power there
    wire m_act   = men_reg & (mode != MODE_DEEP_STBY) & (mode != MODE_SHUTDOWN);
    wire m_fault = m_act & lf_edge & ~m_edge & (mcnt_reg + 4'h1 >= mwin);
    // count slow edges; activity restarts the window
    always_ff @(posedge CLK) begin
        if (RST) begin
            mcnt_reg   <= 4'h0;
            mfault_reg <= 1'b0;
        end else begin
            if (!m_act || m_edge || m_fault)
                mcnt_reg <= 4'h0;
            else if (lf_edge)
                mcnt_reg <= mcnt_reg + 4'h1;
            if (m_fault)
                mfault_reg <= 1'b1;
        end
    end
    // enabled early, a dead slow clock cannot fault; user keeps order
    a_mclk_window: assert property (@(posedge CLK) disable iff (RST)
        m_act && lf_edge && !m_edge && mcnt_reg == mwin - 4'h1 |=> mfault_reg && mcnt_reg == 4'h0)
        else $error("main clock fault not raised at window end");
    a_mclk_idle: assert property (@(posedge CLK) disable iff (RST)
        (mode == MODE_DEEP_STBY || mode == MODE_SHUTDOWN || !men_reg) |=> mcnt_reg == 4'h0)
        else $error("main clock monitor counts while inactive");
    // ------------------------------------------------------------
    // fast clock start-up and stuck monitor
    // ------------------------------------------------------------
    logic [10:0] hcnt_reg;   // edges since start
    logic [15:0] hidle_reg;  // cycles since last edge
    logic        hrun_reg;   // monitoring after start
    logic        good_reg;   // fast_clock_good_flag
    logic        off_reg;    // fast_clock_off_flag
    wire h_restart = hf_start | ext_sel;
    wire h_good = hrun_reg & hf_edge & ~good_reg & (hcnt_reg == 11'(HF_GOOD_EDGES - 1));
    wire h_off  = hrun_reg & ~hf_edge & (hidle_reg == 16'(HF_STUCK_CYC - 1));
    // restart clears both flags; a set in that cycle still wins
    always_ff @(posedge CLK) begin
        if (RST) begin
            hcnt_reg  <= '0;
            hidle_reg <= '0;
            hrun_reg  <= 1'b0;
            good_reg  <= 1'b0;
            off_reg   <= 1'b0;
        end else begin
            if (h_restart) begin
                hcnt_reg  <= '0;
                hidle_reg <= '0;
                hrun_reg  <= 1'b1;
            end else if (hrun_reg) begin
                hidle_reg <= (hf_edge || h_off) ? 16'h0000 : hidle_reg + 16'h0001;
                if (hf_edge && !good_reg)
                    hcnt_reg <= hcnt_reg + 11'h001;
            end
            good_reg <= h_good | (good_reg & ~h_restart & ~h_off);
            off_reg  <= h_off  | (off_reg & ~h_restart);
        end
    end
    a_hf_clear: assert property (@(posedge CLK) disable iff (RST)
        h_restart |=> hcnt_reg == '0 && hidle_reg == '0 && good_reg == $past(h_good) && off_reg == $past(h_off))
        else $error("fast clock flags not cleared at start");
    a_hf_stuck: assert property (@(posedge CLK) disable iff (RST)
        h_off |=> off_reg && !good_reg)
        else $error("stuck fast clock not flagged");
    // ------------------------------------------------------------
    // slow clock stuck monitor, no frequency check
    // ------------------------------------------------------------
    logic [15:0] lidle_reg;  // cycles since last slow edge
    logic        ldead_reg;  // slow clock stuck
    wire l_chk  = (lf_src_reg == LF_XTAL) | (lf_src_reg == LF_EXT);
    wire l_dead = l_chk & ~lf_edge & (lidle_reg == 16'(LF_STUCK_CYC - 1));
    // any edge is good enough; frequency is not judged
    always_ff @(posedge CLK) begin
        if (RST) begin
            lidle_reg <= '0;
            ldead_reg <= 1'b0;
        end else begin
            lidle_reg <= (!l_chk || lf_edge || l_dead) ? 16'h0000 : lidle_reg + 16'h0001;
            ldead_reg <= l_chk & (l_dead | (ldead_reg & ~lf_edge));
        end
    end
    a_lf_internal: assert property (@(posedge CLK) disable iff (RST)
        lf_src_reg == LF_INT |=> lidle_reg == '0 && !ldead_reg)
        else $error("internal slow source is being checked");
    // ------------------------------------------------------------
    // brownout supervisors and warning stage
    // ------------------------------------------------------------
    logic vdd_reg, vbat_reg, bor_reg, nmi_reg;
    wire  trip = arm_reg & s2_reg[P_WARN];
    // violations follow the supplies; trip turns warning into reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            vdd_reg  <= 1'b0;
            vbat_reg <= 1'b0;
            bor_reg  <= 1'b0;
            nmi_reg  <= 1'b0;
            arm_reg  <= 1'b0;
        end else begin
            vdd_reg  <= s2_reg[P_VDD];
            vbat_reg <= s2_reg[P_VBAT];
            bor_reg  <= s2_reg[P_VDD] & ~arm_reg;       // reset only when the warning stage is not armed
            nmi_reg  <= trip;
            if (trip)
                arm_reg <= 1'b0;
            else if (wr_en && PADDR == A_BOR_CFG)
                arm_reg <= PWDATA[0];
        end
    end
    a_bor_follow: assert property (@(posedge CLK) disable iff (RST)
        ##1 vdd_reg == $past(s2_reg[P_VDD]) && vbat_reg == $past(s2_reg[P_VBAT]))
        else $error("brownout violation does not follow supply");
    a_warn_nmi: assert property (@(posedge CLK) disable iff (RST)
        trip |=> NMI && !arm_reg ##1 !NMI)
        else $error("warning trip without nmi and rearm");
    // ------------------------------------------------------------
    // frequency counter
    // ------------------------------------------------------------
    cbm_fcc_t    fst_reg;
    logic [7:0]  frefs_reg;  // reference periods seen
    logic [23:0] fcnt_reg;   // source periods counted
    wire f_end = (fst_reg == FCC_RUN) & ref_edge & (frefs_reg + 8'h01 >= refs_reg);
    // wait a reference edge, count source edges for refs periods
    always_ff @(posedge CLK) begin
        if (RST) begin
            fst_reg   <= FCC_IDLE;
            frefs_reg <= '0;
            fcnt_reg  <= '0;
        end else begin
            case (fst_reg)
                FCC_IDLE, FCC_DONE: if (fcc_go) begin
                    fst_reg  <= FCC_ARM;
                    fcnt_reg <= '0;
                end
                FCC_ARM: if (ref_edge) begin
                    fst_reg   <= FCC_RUN;
                    frefs_reg <= '0;
                end
                FCC_RUN: begin
                    if (src_edge)
                        fcnt_reg <= fcnt_reg + 24'h000001;
                    if (f_end)
                        fst_reg <= FCC_DONE;
                    else if (ref_edge)
                        frefs_reg <= frefs_reg + 8'h01;
                end
                default: fst_reg <= FCC_IDLE;
            endcase
        end
    end
    sequence s_fcc_last;
        fst_reg == FCC_RUN && ref_edge && frefs_reg + 8'h01 >= refs_reg;
    endsequence
    a_fcc_done: assert property (@(posedge CLK) disable iff (RST)
        s_fcc_last |=> fst_reg == FCC_DONE ##1 fst_reg != FCC_RUN)
        else $error("frequency count did not stop at window end");
    // ------------------------------------------------------------
    // boot monitor and boot reset
    // ------------------------------------------------------------
    logic [31:0] btim_reg;   // cycles in current boot attempt
    logic        bact_reg;   // boot routine running
    logic        bfail_reg;  // a boot failed at least once
    logic        brst_reg;
    wire b_fail = bact_reg & (s2_reg[P_CFGE] | s2_reg[P_TRIME] |
                  (btim_reg == 32'(BOOT_TO - 1)));
    // failure restarts the attempt and pulses boot reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            btim_reg  <= '0;
            bact_reg  <= 1'b1;
            bfail_reg <= 1'b0;
            brst_reg  <= 1'b0;
        end else begin
            brst_reg <= b_fail | m_fault;
            if (b_fail) begin
                btim_reg  <= '0;
                bfail_reg <= 1'b1;
            end else if (bact_reg) begin
                btim_reg <= btim_reg + 32'h00000001;
                if (s2_reg[P_BDONE])
                    bact_reg <= 1'b0;
            end
        end
    end
    sequence s_boot_bad;
        bact_reg && (s2_reg[P_CFGE] || s2_reg[P_TRIME]);
    endsequence
    a_boot_fail: assert property (@(posedge CLK) disable iff (RST)
        s_boot_bad |=> BOOT_RST && btim_reg == '0)
        else $error("boot integrity error without boot reset");
    a_fault_rst: assert property (@(posedge CLK) disable iff (RST)
        $rose(mfault_reg) |-> BOOT_RST)
        else $error("main clock fault without boot reset");
    // ------------------------------------------------------------
    // interrupts, write one to clear, set wins
    // ------------------------------------------------------------
    logic [INT_W-1:0] ist_reg;
    logic             irq_reg;
    wire  [INT_W-1:0] ev = {b_fail, f_end, s2_reg[P_VBAT] & ~vbat_reg,
                            s2_reg[P_VDD] & ~vdd_reg, l_dead, h_off, h_good, m_fault};
    // sticky events gated by the mask onto one line
    always_ff @(posedge CLK) begin
        if (RST) begin
            ist_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            ist_reg <= (ist_reg & ~w1c) | ev;
            irq_reg <= |(ist_reg & msk_reg);
        end
    end
    // ------------------------------------------------------------
    // apb slave: one wait state, error on unmapped offset
    // ------------------------------------------------------------
    logic [31:0] rd;
    logic        hit;
    // read mux
    always_comb begin
        rd  = 32'h00000000;
        hit = 1'b1;
        case (PADDR)
            A_MCLK_CFG: rd = {27'h0, mwin_reg, men_reg};
            A_CLK_CFG:  rd = {28'h0, lf_src_reg, hf_ext_reg, 1'b0};
            A_CLK_STAT: rd = {24'h0, ~bact_reg, arm_reg, vbat_reg, vdd_reg,
                              mfault_reg, ldead_reg, off_reg, good_reg};
            A_FCC_CTL:  rd = {16'h0, refs_reg, 6'h0, fst_reg};
            A_FCC_CNT:  rd = {(fst_reg == FCC_DONE), bfail_reg, 6'h0, fcnt_reg};
            A_INT_ST:   rd = {24'h0, ist_reg};
            A_INT_MSK:  rd = {24'h0, msk_reg};
            A_BOR_CFG:  rd = {31'h0, arm_reg};
            default:    hit = 1'b0;
        endcase
    end
    // pready rises one cycle into the access phase
    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= acc & ~pready_reg;
            pslverr_reg <= acc & ~pready_reg & ~hit;
            if (acc && !pready_reg && !PWRITE)
                prdata_reg <= rd;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PRDATA    = prdata_reg;
    assign PREADY    = pready_reg;
    assign PSLVERR   = pslverr_reg;
    assign BOOT_RST  = brst_reg;
    assign VDD_VIOL  = vdd_reg;
    assign VBAT_VIOL = vbat_reg;
    assign BOR_RST   = bor_reg;
    assign NMI       = nmi_reg;
    assign IRQ       = irq_reg;
endmodule : cbm_monitor

// file: verification/cbm_osc_model.sv
// far-side clock sources for the monitor bench
`timescale 1ns/1ps
module cbm_osc_model (
    // run controls
    input  wire logic mclk_on,
    input  wire logic hf_on,
    input  wire logic lf_on,
    // clocks; a stopped one holds its level
    output logic      MCLK_ACT,
    output logic      LF_CLK,
    output logic      HF_CLK,
    output logic      FCC_SRC,
    output logic      FCC_REF
);
    // all well below the 5 MHz input limit
    initial begin
        {MCLK_ACT, LF_CLK, HF_CLK} = 3'h0;
        {FCC_SRC, FCC_REF} = 2'h0;
    end
    always #300 if (mclk_on) MCLK_ACT = ~MCLK_ACT;
    always #1000 if (lf_on) LF_CLK = ~LF_CLK; // slow clock runs from the start
    always #300 if (hf_on) HF_CLK = ~HF_CLK;
    always #300 FCC_SRC = ~FCC_SRC;
    always #3000 FCC_REF = ~FCC_REF;
endmodule : cbm_osc_model

// file: verification/clock_boot_supply_fault_monitor_test.sv
// self-checking bench for the fault monitor
`timescale 1ns/1ps
module clock_boot_supply_fault_monitor_test;
    import cbm_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, se;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        mclk, lf, hf, fsrc, fref, mclk_on, hf_on, lf_on;
    logic        vdd_low, vbat_low, vdd_warn, bcfg_err, trim_err, boot_done;
    logic [1:0]  mode;
    logic        boot_rst, vdd_viol, vbat_viol, bor_rst, nmi, irq;
    int          error_cnt = 0, checks_done = 0, boot_cnt = 0, nmi_cnt = 0;
    // short boot limit keeps the timeout case brief
    cbm_monitor #(.BOOT_TO(50)) u_dut (.CLK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MCLK_ACT(mclk),
        .LF_CLK(lf), .HF_CLK(hf), .FCC_SRC(fsrc), .FCC_REF(fref),
        .VDD_LOW(vdd_low), .VBAT_LOW(vbat_low), .VDD_WARN(vdd_warn),
        .BCFG_ERR(bcfg_err), .TRIM_ERR(trim_err), .BOOT_DONE(boot_done),
        .MODE(mode), .BOOT_RST(boot_rst), .VDD_VIOL(vdd_viol),
        .VBAT_VIOL(vbat_viol), .BOR_RST(bor_rst), .NMI(nmi), .IRQ(irq));
    cbm_osc_model u_osc (.mclk_on(mclk_on), .hf_on(hf_on), .lf_on(lf_on), .MCLK_ACT(mclk),
        .LF_CLK(lf), .HF_CLK(hf), .FCC_SRC(fsrc), .FCC_REF(fref));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // nmi lasts one cycle, boot reset one cycle per failing cycle, so count them
    always @(posedge clk) begin
        boot_cnt <= boot_cnt + int'(boot_rst);
        nmi_cnt  <= nmi_cnt + int'(nmi);
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // one apb transfer; holds the request until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic t_boot;
        int b;
        b = boot_cnt;
        repeat (60) @(posedge clk);
        chk("boot timeout", boot_cnt - b, 1);
        for (int i = 0; i < 2; i++) begin
            b = boot_cnt;
            {trim_err, bcfg_err} <= 2'h1 << i;
            repeat (3) @(posedge clk);
            {trim_err, bcfg_err} <= 2'h0;
            repeat (5) @(posedge clk);
            chk("boot err", boot_cnt > b, 1);
        end
        boot_done <= 1'b1;
    endtask : t_boot
    task automatic t_regs;
        apb(0, A_MCLK_CFG, 32'h0);
        chk("mclk cfg", rd, 32'h18);
        apb(0, 8'h40, 32'h0);
        chk("slverr", se, 1);
    endtask : t_regs
    // alive clock gives no fault, stopped one does
    task automatic t_mclk;
        int b;
        apb(1, A_INT_MSK, 32'h1);
        apb(1, A_MCLK_CFG, 32'h5);
        b = boot_cnt;
        repeat (60) @(posedge clk);
        chk("alive", boot_cnt - b, 0);
        mclk_on <= 1'b0;
        repeat (60) @(posedge clk);
        chk("dead", boot_cnt > b, 1);
        chk("irq", irq, 1);
        mclk_on <= 1'b1;
        apb(1, A_MCLK_CFG, 32'h0);
        apb(0, A_CLK_STAT, 32'h0);
        chk("fault bit", rd[ST_MFAULT], 1);
        apb(1, A_INT_ST, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq clr", irq, 0);
    endtask : t_mclk
    task automatic t_mode;
        int b;
        for (int i = 0; i < 2; i++) begin
            mode <= MODE_DEEP_STBY + 2'(i);
            apb(1, A_MCLK_CFG, 32'h5);
            b = boot_cnt;
            mclk_on <= 1'b0;
            repeat (80) @(posedge clk);
            chk("asleep", boot_cnt - b, 0);
            mclk_on <= 1'b1;
            apb(1, A_MCLK_CFG, 32'h0);
        end
        mode <= 2'h0;
    endtask : t_mode
    task automatic t_supply;
        int k;
        apb(1, A_BOR_CFG, 32'h1);
        {vdd_low, vbat_low} <= 2'h3;
        repeat (5) @(posedge clk);
        chk("viol", {vdd_viol, vbat_viol, bor_rst}, 3'h6);
        k = nmi_cnt;
        vdd_warn <= 1'b1;
        repeat (6) @(posedge clk);
        chk("nmi", nmi_cnt - k, 1);
        chk("bor", bor_rst, 1);
        {vdd_low, vbat_low, vdd_warn} <= 3'h0;
        repeat (5) @(posedge clk);
        chk("clear", {vdd_viol, vbat_viol, bor_rst}, 3'h0);
    endtask : t_supply
    // 1024 fast edges at 6 cycles each
    task automatic t_fast;
        apb(1, A_CLK_CFG, 32'h1);
        repeat (6500) @(posedge clk);
        apb(0, A_CLK_STAT, 32'h0);
        chk("good", rd[1:0], 2'h1);
        apb(1, A_CLK_CFG, 32'h2);
        apb(0, A_CLK_STAT, 32'h0);
        chk("flags", rd[1:0], 2'h0);
        hf_on <= 1'b0;
        repeat (40) @(posedge clk);
        apb(0, A_CLK_STAT, 32'h0);
        chk("off", rd[1:0], 2'h2);
    endtask : t_fast
    // crystal-sourced slow clock stops, then internal source
    task automatic t_slow;
        apb(1, A_CLK_CFG, 32'h6);
        lf_on <= 1'b0;
        repeat (2100) @(posedge clk);
        apb(0, A_CLK_STAT, 32'h0);
        chk("slow dead", rd[ST_LFDEAD], 1);
        apb(1, A_CLK_CFG, 32'h2);
        apb(0, A_CLK_STAT, 32'h0);
        chk("slow internal", rd[ST_LFDEAD], 0);
        lf_on <= 1'b1;
    endtask : t_slow
    // ten source periods fit one reference period
    task automatic t_fcc;
        apb(1, A_FCC_CTL, 32'h101);
        repeat (200) @(posedge clk);
        apb(0, A_FCC_CNT, 32'h0);
        chk("fcc done", rd[31], 1);
        chk("fcc count", rd[23:0] inside {[9:11]}, 1);
    endtask : t_fcc
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {vdd_low, vbat_low, vdd_warn, bcfg_err, trim_err, boot_done} = '0;
        {mode, mclk_on, hf_on, lf_on, rst} = 6'hf;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_boot();
        t_regs();
        t_mclk();
        t_mode();
        t_supply();
        t_fast();
        t_slow();
        t_fcc();
        wrap_up();
    end
    // the run needs some 9500 cycles
    initial begin
        #2000000;
        error_cnt++;
        wrap_up();
    end
endmodule : clock_boot_supply_fault_monitor_test
